/* verilog/amp_ctrl_regs.vh */
`ifndef AMP_CTRL_REGS_VH
`define AMP_CTRL_REGS_VH
`define OFS_SOFT_RESET      8'h01
`define OFS_OUTPUT_CONFIG   8'h02
`define OFS_POWER_STATE     8'h03
`define OFS_PIN_SETUP2      8'h75
`define OFS_MISC_SETUP      8'h76
`define OFS_ERROR_CLEAR     8'h78
`define RST_SOFT_RESET      8'h00
`define RST_OUTPUT_CONFIG   8'h00
`define RST_POWER_STATE     8'h10
`define RST_PIN_SETUP2      8'h00
`define RST_MISC_SETUP      8'h00
`define RST_ERROR_CLEAR     8'h00
`define BIT_CORE_RESET      4
`define BIT_REG_RESET       0
`define BIT_PARALLEL        2
`define BIT_HOLD_RESET      4
`define BIT_MUTE            3
`define FSW_HI              6
`define FSW_LO              4
`define MOD_HI              1
`define MOD_LO              0
`define STATE_HI            1
`define STATE_LO            0
`define FSW_768K            3'h0
`define FSW_384K            3'h1
`define FSW_480K            3'h3
`define FSW_576K            3'h4
`define MOD_BD              2'h0
`define MOD_ONE_SIDE        2'h1
`define MOD_HYBRID          2'h2
`define DEV_DEEP_SLEEP      2'h0
`define DEV_SLEEP           2'h1
`define DEV_HIZ             2'h2
`define DEV_PLAY            2'h3
`define RAMP_STEPS          8'hC0
`define CORE_RESET_CYCLES   8'h10
`endif

/* verilog/volume_ramp.v */
`timescale 1ns/10ps
`default_nettype none
`include "amp_ctrl_regs.vh"
// Soft mute ramp: walks gain one step per tick toward target, avoiding pops
module volume_ramp #(
   parameter WIDTH = 8
) (
   input  wire             mclk,
   input  wire             nrst,
   input  wire             clear,
   input  wire             tick,
   input  wire             mute,
   output reg  [WIDTH-1:0] gain,
   output reg              muted
);
   wire [WIDTH-1:0] target;
   assign target = mute ? {WIDTH{1'b0}} : `RAMP_STEPS;

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         gain  <= {WIDTH{1'b0}};
         muted <= 1'b1;
      end else if (clear) begin
         gain  <= {WIDTH{1'b0}};
         muted <= 1'b1;
      end else begin
         if (tick && gain > target) begin
            gain <= gain - 1'b1;
         end else if (tick && gain < target) begin
            gain <= gain + 1'b1;
         end
         muted <= (gain == {WIDTH{1'b0}});
      end
   end
endmodule // volume_ramp
`default_nettype wire

/* verilog/amp_device_control_regs.v */
`timescale 1ns/10ps
`default_nettype none
`include "amp_ctrl_regs.vh"
module amp_device_control_regs #(
   parameter TICK_DIV = 12'd1000
) (
   input  wire       mclk,
   input  wire       nrst,
   input  wire       wr_en,
   input  wire       rd_en,
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   output reg  [7:0] rdata,
   output reg        rvalid,
   output reg  [2:0] switching_freq_select,
   output reg        parallel_output_select,
   output reg  [1:0] modulation_scheme,
   output reg        processor_hold_reset,
   output reg        coef_clear,
   output reg        core_reset_active,
   output reg  [1:0] device_state,
   output reg        stage_enable,
   output reg        config_fault,
   output reg  [7:0] volume_gain,
   output reg        mute_done,
   output reg  [7:0] pin_setup_second,
   output reg  [7:0] miscellaneous_setup,
   output reg  [7:0] error_flag_clear
);
   reg  [7:0] output_stage_config;
   reg  [7:0] power_state_mute_control;
   reg  [7:0] core_cnt;
   reg        reg_reset_pend;
   reg  [11:0] div_cnt;
   reg        tick;
   wire [7:0] gain;
   wire       muted;
   wire       core_busy;
   wire       wr_reset;
   wire       fsw_ok;
   wire       mod_ok;
   wire       core_start;
   wire       reg_start;

   // Only the four listed rates are legal; every other code is reserved
   function legal_fsw;
      input [2:0] code;
      begin
         case (code)
            `FSW_768K: legal_fsw = 1'b1;
            `FSW_384K: legal_fsw = 1'b1;
            `FSW_480K: legal_fsw = 1'b1;
            `FSW_576K: legal_fsw = 1'b1;
            default:   legal_fsw = 1'b0;
         endcase
      end
   endfunction

   // Code 11 has no scheme behind it, so it is refused like a reserved rate
   function legal_mod;
      input [1:0] code;
      begin
         case (code)
            `MOD_BD:       legal_mod = 1'b1;
            `MOD_ONE_SIDE: legal_mod = 1'b1;
            `MOD_HYBRID:   legal_mod = 1'b1;
            default:       legal_mod = 1'b0;
         endcase
      end
   endfunction

   // Soft resets restore the same image that power-up loads
   function [7:0] reset_value;
      input [7:0] ofs;
      begin
         case (ofs)
            `OFS_OUTPUT_CONFIG: reset_value = `RST_OUTPUT_CONFIG;
            `OFS_POWER_STATE:   reset_value = `RST_POWER_STATE;
            `OFS_PIN_SETUP2:    reset_value = `RST_PIN_SETUP2;
            `OFS_MISC_SETUP:    reset_value = `RST_MISC_SETUP;
            `OFS_ERROR_CLEAR:   reset_value = `RST_ERROR_CLEAR;
            default:            reset_value = `RST_SOFT_RESET;
         endcase
      end
   endfunction

   assign core_busy  = (core_cnt != 8'h00);
   assign wr_reset   = wr_en && (addr == `OFS_SOFT_RESET);
   // A reset request during a running core reset is dropped, like any write
   assign core_start = wr_reset && wdata[`BIT_CORE_RESET] && !core_busy;
   assign reg_start  = wr_reset && wdata[`BIT_REG_RESET] && !core_busy;
   assign fsw_ok     = legal_fsw(output_stage_config[`FSW_HI:`FSW_LO]);
   assign mod_ok     = legal_mod(output_stage_config[`MOD_HI:`MOD_LO]);

   // Core reset holds the chain for a fixed span so the coefficient wipe completes
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         core_cnt       <= 8'h00;
         reg_reset_pend <= 1'b0;
      end else begin
         if (core_start) begin
            core_cnt <= `CORE_RESET_CYCLES;
         end else if (core_busy) begin
            core_cnt <= core_cnt - 8'h01;
         end
         // Request bits are never stored, so they read back zero after acting
         reg_reset_pend <= reg_start;
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         output_stage_config      <= `RST_OUTPUT_CONFIG;
         power_state_mute_control <= `RST_POWER_STATE;
         pin_setup_second         <= `RST_PIN_SETUP2;
         miscellaneous_setup      <= `RST_MISC_SETUP;
         error_flag_clear         <= `RST_ERROR_CLEAR;
      end else if (core_busy || reg_reset_pend) begin
         output_stage_config      <= reset_value(`OFS_OUTPUT_CONFIG);
         power_state_mute_control <= reset_value(`OFS_POWER_STATE);
         pin_setup_second         <= reset_value(`OFS_PIN_SETUP2);
         miscellaneous_setup      <= reset_value(`OFS_MISC_SETUP);
         error_flag_clear         <= reset_value(`OFS_ERROR_CLEAR);
      end else if (wr_en) begin
         case (addr)
            `OFS_OUTPUT_CONFIG: output_stage_config      <= wdata;
            `OFS_POWER_STATE:   power_state_mute_control <= wdata;
            `OFS_PIN_SETUP2:    pin_setup_second         <= wdata;
            `OFS_MISC_SETUP:    miscellaneous_setup      <= wdata;
            `OFS_ERROR_CLEAR:   error_flag_clear         <= wdata;
            default: ;
         endcase
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata  <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rvalid <= rd_en;
         if (rd_en) begin
            case (addr)
               `OFS_SOFT_RESET:    rdata <= 8'h00;
               `OFS_OUTPUT_CONFIG: rdata <= output_stage_config;
               `OFS_POWER_STATE:   rdata <= power_state_mute_control;
               `OFS_PIN_SETUP2:    rdata <= pin_setup_second;
               `OFS_MISC_SETUP:    rdata <= miscellaneous_setup;
               `OFS_ERROR_CLEAR:   rdata <= error_flag_clear;
               default:            rdata <= 8'h00;
            endcase
         end
      end
   end

   // Ramp step rate; one tick per TICK_DIV clocks
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         div_cnt <= 12'h000;
         tick    <= 1'b0;
      end else if (div_cnt >= TICK_DIV - 12'd1) begin
         div_cnt <= 12'h000;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 12'h001;
         tick    <= 1'b0;
      end
   end

   volume_ramp #(
      .WIDTH (8)
   ) u_ramp (
      .mclk  (mclk),
      .nrst  (nrst),
      .clear (core_busy),
      .tick  (tick),
      .mute  (power_state_mute_control[`BIT_MUTE]),
      .gain  (gain),
      .muted (muted)
   );

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         switching_freq_select  <= `FSW_768K;
         parallel_output_select <= 1'b0;
         modulation_scheme      <= `MOD_BD;
         processor_hold_reset   <= 1'b1;
         coef_clear             <= 1'b0;
         core_reset_active      <= 1'b0;
         device_state           <= `DEV_DEEP_SLEEP;
         stage_enable           <= 1'b0;
         config_fault           <= 1'b0;
         volume_gain            <= 8'h00;
         mute_done              <= 1'b1;
      end else begin
         switching_freq_select  <= output_stage_config[`FSW_HI:`FSW_LO];
         parallel_output_select <= output_stage_config[`BIT_PARALLEL];
         modulation_scheme      <= output_stage_config[`MOD_HI:`MOD_LO];
         processor_hold_reset   <= power_state_mute_control[`BIT_HOLD_RESET] | core_busy;
         coef_clear             <= core_busy;
         core_reset_active      <= core_busy;
         device_state           <= power_state_mute_control[`STATE_HI:`STATE_LO];
         config_fault           <= !(fsw_ok && mod_ok);
         // Only play drives the bridge, and never on a reserved setting
         stage_enable           <= (power_state_mute_control[`STATE_HI:`STATE_LO] == `DEV_PLAY)
                                   && fsw_ok && mod_ok && !core_busy;
         volume_gain            <= gain;
         mute_done              <= muted;
      end
   end
endmodule // amp_device_control_regs
`default_nettype wire

/* sim/amp_regs_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module amp_regs_checker (
   input wire logic       mclk,
   input wire logic       nrst,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic [2:0] switching_freq_select,
   input wire logic [1:0] modulation_scheme,
   input wire logic       processor_hold_reset,
   input wire logic       coef_clear,
   input wire logic       core_reset_active,
   input wire logic [1:0] device_state,
   input wire logic       stage_enable,
   input wire logic       config_fault,
   input wire logic [7:0] volume_gain
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_core_req;
      wr_en && addr == 8'h01 && wdata[4] && !core_reset_active && !coef_clear;
   endsequence
   sequence s_core_span;
      core_reset_active [*8] ##1 core_reset_active [*8] ##1 !core_reset_active;
   endsequence
   property p_core; s_core_req |-> ##[1:2] coef_clear && processor_hold_reset; endproperty
   a_core: assert property (p_core) else $error("core reset missing");
   property p_span; $rose(core_reset_active) |-> s_core_span; endproperty
   a_span: assert property (p_span) else $error("core span wrong");
   property p_hold; $rose(core_reset_active) |-> ##[0:1] processor_hold_reset; endproperty
   a_hold: assert property (p_hold) else $error("processor not held");
   property p_rd0; rd_en && addr == 8'h01 |=> rdata == 8'h00; endproperty
   a_rd0: assert property (p_rd0) else $error("reset bits read back");
   property p_stage; stage_enable |-> device_state == 2'h3; endproperty
   a_stage: assert property (p_stage) else $error("stage on outside play");
   property p_fault; config_fault |-> !stage_enable; endproperty
   a_fault: assert property (p_fault) else $error("stage on with fault");
   // Three cycles of settling before the fault flag must follow the fields
   property p_cfg;
      (switching_freq_select inside {3'h2, 3'h5, 3'h6, 3'h7} || modulation_scheme == 2'h3) [*3]
      |-> config_fault;
   endproperty
   a_cfg: assert property (p_cfg) else $error("reserved code missed");
   property p_ramp;
      !core_reset_active && !coef_clear && $changed(volume_gain) |->
      volume_gain == $past(volume_gain) + 8'h01 || volume_gain == $past(volume_gain) - 8'h01;
   endproperty
   a_ramp: assert property (p_ramp) else $error("gain jumped");
endmodule // amp_regs_checker
bind amp_device_control_regs amp_regs_checker i_chk (.*);
`default_nettype wire

/* sim/host_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model #(
   parameter SETTLE = 40
) (
   input  wire logic       mclk,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid,
   output var  logic       wr_en,
   output var  logic       rd_en,
   output var  logic [7:0] addr,
   output var  logic [7:0] wdata
);
   initial {wr_en, rd_en, addr, wdata} = 18'h00000;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      {wr_en, addr, wdata} <= {1'h1, a, d};
      @(posedge mclk);
      {wr_en, wdata} <= {1'h0, ~d};
   endtask
   // Read data is registered, so it is taken at the edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic vld);
      @(posedge mclk);
      {rd_en, addr} <= {1'h1, a};
      @(posedge mclk);
      rd_en <= 1'h0;
      @(posedge mclk);
      d = rdata;
      vld = rvalid;
   endtask
   // Settle time scaled down; real supplies and clocks need milliseconds
   task automatic startup();
      wr(8'h03, 8'h02);
      repeat (SETTLE) @(posedge mclk);
      wr(8'h03, 8'h03);
   endtask
   task automatic shutdown();
      wr(8'h03, 8'h02);
      repeat (SETTLE) @(posedge mclk);
   endtask
endmodule // host_ctrl_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic       mclk, nrst, wr_en, rd_en, rvalid, parallel_output_select, processor_hold_reset;
   logic       coef_clear, core_reset_active, stage_enable, config_fault, mute_done;
   logic [7:0] addr, wdata, rdata, volume_gain, pin_setup_second, v;
   logic [7:0] miscellaneous_setup, error_flag_clear;
   logic [2:0] switching_freq_select;
   logic [1:0] modulation_scheme, device_state;
   logic       rv;
   int         fails = 0;
   int         compares = 0;
   int         i;
   amp_device_control_regs #(.TICK_DIV(12'h002)) i_dut (.*);
   host_ctrl_model #(.SETTLE(40)) i_host (.*);
   initial begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      i_host.rd(a, v, rv);
      chk("rdata", v, e);
      chk("rvalid", rv, 8'h01);
   endtask
   task automatic wait_c(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wrap_up();
      if (fails == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #500000;
      fails++;
      wrap_up();
   end
   initial begin
      nrst = 1'h0;
      repeat (3) @(posedge mclk);
      nrst <= 1'h1;
      rchk(8'h01, 8'h00);
      rchk(8'h03, 8'h10);
      rchk(8'h42, 8'h00);
      chk("hold", processor_hold_reset, 8'h01);
      i_host.startup();
      wait_c(3);
      chk("hold", processor_hold_reset, 8'h00);
      for (i = 0; i < 8; i++) begin
         v = {1'h0, i[2:0], 1'h0, i[0], i[1:0]};
         i_host.wr(8'h02, v);
         wait_c(3);
         chk("cfg", {switching_freq_select, parallel_output_select,
                     modulation_scheme}, {v[6:4], v[2:0]});
         chk("stage", stage_enable, !(i == 2 || i > 4 || i[1:0] == 2'h3));
         chk("fault", config_fault, i == 2 || i > 4 || i[1:0] == 2'h3);
         rchk(8'h02, v);
      end
      i_host.wr(8'h02, 8'h00);
      for (i = 0; i < 4; i++) begin
         i_host.wr(8'h03, i[7:0]);
         wait_c(3);
         chk("state", {device_state, stage_enable}, {i[1:0], i == 3});
      end
      wait_c(500);
      chk("gain", volume_gain, 8'hC0);
      i_host.wr(8'h03, 8'h0B);
      wait_c(60);
      chk("done", mute_done, 8'h00);
      wait_c(500);
      chk("gain", {volume_gain[7:1], mute_done}, 8'h01);
      i_host.wr(8'h75, 8'hA5);
      i_host.wr(8'h76, 8'h5A);
      i_host.wr(8'h78, 8'h3C);
      i_host.wr(8'h02, 8'h15);
      wait_c(3);
      chk("pins", pin_setup_second, 8'hA5);
      chk("misc", miscellaneous_setup, 8'h5A);
      chk("clear", error_flag_clear, 8'h3C);
      rchk(8'h02, 8'h15);
      i_host.wr(8'h01, 8'h01);
      wait_c(1);
      chk("coef", coef_clear, 8'h00);
      wait_c(2);
      chk("pins", pin_setup_second, 8'h00);
      chk("misc", miscellaneous_setup, 8'h00);
      chk("clear", error_flag_clear, 8'h00);
      rchk(8'h02, 8'h00);
      rchk(8'h01, 8'h00);
      // Mute first so the core reset does not cut a running ramp
      i_host.wr(8'h03, 8'h0B);
      wait_c(500);
      i_host.wr(8'h01, 8'h10);
      wait_c(2);
      chk("core", {coef_clear, processor_hold_reset}, 8'h03);
      chk("busy", core_reset_active, 8'h01);
      wait_c(20);
      chk("core", {coef_clear, processor_hold_reset}, 8'h01);
      chk("busy", core_reset_active, 8'h00);
      rchk(8'h03, 8'h10);
      i_host.shutdown();
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
